/* File: rtl/ssp_pwm_channel.sv */
`timescale 1ns/100ps
`default_nettype none

module ssp_pwm_channel
   import ssp_pkg::*;
#(
   parameter int          CHANNEL_INDEX = 0,
   parameter int          CLK_HZ        = CLOCK_HZ,
   parameter logic [31:0] INIT_LOW_VOLT = RST_VOLT,
   parameter logic        INIT_RELAY    = 1'b0
) (
   input  wire logic                  clock,
   input  wire logic                  sys_rst,
   input  wire logic                  group_start_flag_a,
   input  wire logic                  group_start_flag_b,
   input  wire logic                  group_start_flag_c,
   input  wire logic                  group_start_flag_d,
   input  wire logic                  pwm_control_write,
   input  wire ssp_ctrl_t             pwm_control_group,
   output ssp_out_t                   channel_out
);

   // parameters the logic cannot serve are refused at elaboration
   if (CHANNEL_INDEX < 0 || CHANNEL_INDEX >= NUM_CHANNELS) begin : g_bad_index
      $error("channel index out of range");
   end
   if (CLK_HZ < MAX_FREQ_HZ) begin : g_bad_clock
      $error("clock too slow for top frequency");
   end

   // ----------------------------------------------------------------
   // real32 helpers
   // ----------------------------------------------------------------
   // real32 to unsigned integer, negative and nan forced to zero
   function automatic logic [31:0] real_to_uint(input logic [31:0] r);
      logic [7:0]  e;
      logic [55:0] m;
      logic [31:0] res;
      e   = r[EXP_POS +: EXP_W];
      m   = {32'h00000000, 1'b1, r[MANT_W-1:0]};
      res = 32'h00000000;
      if (!r[SIGN_POS] && e >= 8'(EXP_BIAS) && e < 8'(EXP_BIAS + 32)) begin
         m   = m << (e - 8'(EXP_BIAS));
         res = m[MANT_W +: 32];
      end
      return res;
   endfunction

   // clamp a positive real to an upper bound, negative to zero
   function automatic logic [31:0] real_clamp(input logic [31:0] r,
                                              input logic [31:0] hi);
      logic [31:0] res;
      res = r;
      if (r[SIGN_POS])
         res = 32'h00000000;
      else if (r[30:0] > hi[30:0])
         res = hi;
      return res;
   endfunction

   // real fraction 0..1 as 16-bit fixed point, 1.0 = 0x10000 saturated
   function automatic logic [16:0] frac_to_fix(input logic [31:0] r);
      logic [7:0]  e;
      logic [40:0] m;
      logic [16:0] res;
      e   = r[EXP_POS +: EXP_W];
      m   = {17'h00000, 1'b1, r[MANT_W-1:0]};
      res = 17'h00000;
      if (!r[SIGN_POS]) begin
         if (e >= 8'(EXP_BIAS))
            res = 17'h10000;
         else if (e >= 8'(EXP_BIAS - 16)) begin
            m   = m >> (8'(EXP_BIAS) - e);
            res = {1'b0, m[MANT_W-16 +: 16]};
         end
      end
      return res;
   endfunction

   // ----------------------------------------------------------------
   // start selection
   // ----------------------------------------------------------------
   localparam int GRP = CHANNEL_INDEX / GROUP_SIZE;
   logic [NUM_GROUPS-1:0] grp_flags;
   logic                  grp_run;
   logic                  run_req;

   assign grp_flags = {group_start_flag_d, group_start_flag_c,
                       group_start_flag_b, group_start_flag_a};
   assign grp_run = grp_flags[GRP];

   // ----------------------------------------------------------------
   // control state
   // ----------------------------------------------------------------
   logic        src_q, src_d;
   logic        lrun_q, lrun_d;
   logic [31:0] freq_q, freq_d;
   logic [16:0] frac_q, frac_d;
   logic [31:0] lo_v_q, lo_v_d;
   logic [31:0] hi_v_q, hi_v_d;
   logic        relay_q, relay_d;
   logic        recalc_q, recalc_d;

   always_comb begin
      src_d    = src_q;
      lrun_d   = lrun_q;
      freq_d   = freq_q;
      frac_d   = frac_q;
      lo_v_d   = lo_v_q;
      hi_v_d   = hi_v_q;
      relay_d  = relay_q;
      recalc_d = 1'b0;
      if (pwm_control_write) begin
         src_d    = pwm_control_group.start_source_select;
         lrun_d   = pwm_control_group.local_run_flag;
         freq_d   = real_to_uint(real_clamp(pwm_control_group.frequency,
                                            REAL_FMAX));
         frac_d   = frac_to_fix(pwm_control_group.high_time_fraction);
         lo_v_d   = real_clamp(pwm_control_group.low_state_voltage,
                               REAL_TEN);
         hi_v_d   = real_clamp(pwm_control_group.high_state_voltage,
                               REAL_TEN);
         relay_d  = pwm_control_group.relay_close;
         recalc_d = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         src_q    <= 1'b0;
         lrun_q   <= 1'b0;
         freq_q   <= RST_FREQ;
         frac_q   <= 17'h00000;
         lo_v_q   <= INIT_LOW_VOLT;
         hi_v_q   <= INIT_LOW_VOLT;
         relay_q  <= INIT_RELAY;
         recalc_q <= 1'b0;
      end else begin
         src_q    <= src_d;
         lrun_q   <= lrun_d;
         freq_q   <= freq_d;
         frac_q   <= frac_d;
         lo_v_q   <= lo_v_d;
         hi_v_q   <= hi_v_d;
         relay_q  <= relay_d;
         recalc_q <= recalc_d;
      end
   end

   assign run_req = src_q ? grp_run : lrun_q;

   // ----------------------------------------------------------------
   // period computation
   // ----------------------------------------------------------------
   logic        div_done;
   logic [31:0] div_quot;

   ssp_ratio #(
      .W       (32)
   ) u_ratio (
      .clock   (clock),
      .sys_rst (sys_rst),
      .start   (recalc_q),
      .num     (32'(CLK_HZ)),
      .den     (freq_q),
      .done    (div_done),
      .quot    (div_quot)
   );

   logic [31:0] per_q, per_d;
   logic [31:0] hi_q, hi_d;
   logic [48:0] hi_prod;

   // high time is fraction of period
   assign hi_prod = div_quot * frac_q;

   always_comb begin
      per_d = per_q;
      hi_d  = hi_q;
      if (div_done) begin
         // zero frequency leaves a steady low level
         per_d = (freq_q == 32'h00000000) ? 32'h00000000 : div_quot;
         hi_d  = hi_prod[47:16];
      end
   end

   // ----------------------------------------------------------------
   // waveform counter
   // ----------------------------------------------------------------
   logic [31:0] cnt_q, cnt_d;
   logic        act_q, act_d;
   logic        run_q, run_d;

   always_comb begin
      cnt_d = cnt_q;
      act_d = 1'b0;
      run_d = run_q;
      if (!run_req || per_q == 32'h00000000) begin
         // stopping restarts this channel's counter at phase zero
         cnt_d = 32'h00000000;
         run_d = 1'b0;
      end else begin
         run_d = 1'b1;
         cnt_d = (cnt_q >= per_q - 32'h00000001) ? 32'h00000000
                                                 : cnt_q + 32'h00000001;
         act_d = (cnt_d < hi_q);
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         per_q <= 32'h00000000;
         hi_q  <= 32'h00000000;
         cnt_q <= 32'h00000000;
         act_q <= 1'b0;
         run_q <= 1'b0;
      end else begin
         per_q <= per_d;
         hi_q  <= hi_d;
         cnt_q <= cnt_d;
         act_q <= act_d;
         run_q <= run_d;
      end
   end

   assign channel_out.voltage      = act_q ? hi_v_q : lo_v_q;
   assign channel_out.relay_closed = relay_q;
   assign channel_out.active       = act_q;
   assign channel_out.running      = run_q;

endmodule

`default_nettype wire

/* File: rtl/ssp_pkg.sv */
`default_nettype none
package ssp_pkg;

   // ----------------------------------------------------------------
   // channel and group layout
   // ----------------------------------------------------------------
   localparam int NUM_CHANNELS   = 12;
   localparam int GROUP_SIZE     = 3;
   localparam int NUM_GROUPS     = 4;
   localparam int CH_IDX_W       = 4;
   localparam int GRP_IDX_W      = 2;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLOCK_HZ       = 50000000;
   localparam int MAX_FREQ_HZ    = 10000;
   localparam int MIN_PERIOD_CYC = CLOCK_HZ / MAX_FREQ_HZ;

   // ----------------------------------------------------------------
   // 32-bit real encoding
   // ----------------------------------------------------------------
   localparam int REAL_W         = 32;
   localparam int EXP_POS        = 23;
   localparam int EXP_W          = 8;
   localparam int MANT_W         = 23;
   localparam int EXP_BIAS       = 127;
   localparam int SIGN_POS       = 31;
   localparam logic [31:0] REAL_ONE   = 32'h3F800000;
   localparam logic [31:0] REAL_TEN   = 32'h41200000;
   localparam logic [31:0] REAL_FMAX  = 32'h461C4000;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_FREQ   = 32'h00000000;
   localparam logic [31:0] RST_FRAC   = 32'h00000000;
   localparam logic [31:0] RST_VOLT   = 32'h00000000;

   // values written together by host software
   typedef struct packed {
      logic        start_source_select;
      logic        local_run_flag;
      logic [31:0] frequency;
      logic [31:0] high_time_fraction;
      logic [31:0] low_state_voltage;
      logic [31:0] high_state_voltage;
      logic        relay_close;
   } ssp_ctrl_t;

   typedef struct packed {
      logic [31:0] voltage;
      logic        relay_closed;
      logic        active;
      logic        running;
   } ssp_out_t;

endpackage

`default_nettype wire

/* File: rtl/ssp_ratio.sv */
`timescale 1ns/100ps
`default_nettype none

// sequential divider: quotient = num / den, unsigned, one bit per cycle
module ssp_ratio #(
   parameter int W = 32
) (
   input  wire logic         clock,
   input  wire logic         sys_rst,
   input  wire logic         start,
   input  wire logic [W-1:0] num,
   input  wire logic [W-1:0] den,
   output logic              done,
   output logic [W-1:0]      quot
);

   // the shift path needs at least two bits
   if (W < 2) begin : g_bad_width
      $error("divider width below two bits");
   end

   logic [W-1:0]         q_q, q_d;
   logic [W:0]           r_q, r_d;
   logic [W-1:0]         n_q, n_d;
   logic [W-1:0]         d_q, d_d;
   logic [$clog2(W):0]   cnt_q, cnt_d;
   logic                 busy_q, busy_d;
   logic                 done_q, done_d;
   logic [W:0]           trial;

   always_comb begin
      q_d    = q_q;
      r_d    = r_q;
      n_d    = n_q;
      d_d    = d_q;
      cnt_d  = cnt_q;
      busy_d = busy_q;
      done_d = 1'b0;
      trial  = {r_q[W-1:0], n_q[W-1]};
      if (start) begin
         n_d    = num;
         d_d    = den;
         r_d    = '0;
         q_d    = '0;
         cnt_d  = '0;
         busy_d = 1'b1;
      end else if (busy_q) begin
         n_d = {n_q[W-2:0], 1'b0};
         if (trial >= {1'b0, d_q}) begin
            r_d = trial - {1'b0, d_q};
            q_d = {q_q[W-2:0], 1'b1};
         end else begin
            r_d = trial;
            q_d = {q_q[W-2:0], 1'b0};
         end
         cnt_d = cnt_q + 1'b1;
         if (cnt_q == ($clog2(W)+1)'(W-1)) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         q_q    <= '0;
         r_q    <= '0;
         n_q    <= '0;
         d_q    <= '0;
         cnt_q  <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         q_q    <= q_d;
         r_q    <= r_d;
         n_q    <= n_d;
         d_q    <= d_d;
         cnt_q  <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   assign done = done_q;
   assign quot = q_q;

endmodule

`default_nettype wire

/* File: testbench/ssp_chk_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module ssp_chk
   import ssp_pkg::*;
#(
   parameter int          CHANNEL_INDEX = 0,
   parameter logic [31:0] INIT_LOW_VOLT = RST_VOLT,
   parameter logic        INIT_RELAY    = 1'b0
) (
   input wire logic      clock,
   input wire logic      sys_rst,
   input wire logic      group_start_flag_a,
   input wire logic      group_start_flag_b,
   input wire logic      group_start_flag_c,
   input wire logic      group_start_flag_d,
   input wire logic      pwm_control_write,
   input wire ssp_ctrl_t pwm_control_group,
   input wire ssp_out_t  channel_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic [3:0] flags;
   logic       sel;
   ssp_ctrl_t  c_q;
   ssp_ctrl_t  c_d;
   logic [5:0] n_q;
   logic [5:0] n_d;
   assign flags = {group_start_flag_d, group_start_flag_c,
                   group_start_flag_b, group_start_flag_a};
   assign sel = c_q.start_source_select ? flags[CHANNEL_INDEX / 3]
                                        : c_q.local_run_flag;
   // expected level after the 0..10 V clamp, negatives to zero
   function automatic logic [31:0] lim(input logic [31:0] v);
      lim = v[SIGN_POS] ? 32'h00000000 : ((v > REAL_TEN) ? REAL_TEN : v);
   endfunction
   // counts enabled cycles; reload takes about 35 cycles
   always_comb begin
      c_d = pwm_control_write ? pwm_control_group : c_q;
      n_d = n_q + 6'(n_q != 6'h3F);
      if (!sel || pwm_control_write || c_q.frequency < REAL_ONE ||
          c_q.frequency[SIGN_POS]) begin
         n_d = 6'h00;
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         c_q <= {2'b00, 64'h0, INIT_LOW_VOLT, INIT_LOW_VOLT, INIT_RELAY};
         n_q <= 6'h00;
      end else begin
         c_q <= c_d;
         n_q <= n_d;
      end
   end
   reset_values_a: assert property (
      disable iff (1'b0) sys_rst |=>
      channel_out.voltage == INIT_LOW_VOLT && !channel_out.running &&
      channel_out.relay_closed == INIT_RELAY && !channel_out.active)
      else $error("outputs wrong after reset");
   relay_follow_a: assert property (pwm_control_write |=>
      channel_out.relay_closed == $past(pwm_control_group.relay_close))
      else $error("relay did not take written value");
   relay_hold_a: assert property (!pwm_control_write |=>
      $stable(channel_out.relay_closed)) else $error("relay moved unasked");
   run_stop_a: assert property (!sel |=>
      !channel_out.running && !channel_out.active)
      else $error("channel runs while stopped");
   run_start_a: assert property (n_q == 6'd40 |->
      channel_out.running) else $error("channel failed to start");
   active_run_a: assert property (channel_out.active |->
      channel_out.running) else $error("active while not running");
   low_level_a: assert property (!channel_out.active |->
      channel_out.voltage == lim(c_q.low_state_voltage))
      else $error("low level wrong");
   high_level_a: assert property (channel_out.active |->
      channel_out.voltage == lim(c_q.high_state_voltage))
      else $error("high level wrong");
   volt_range_a: assert property (channel_out.voltage <= REAL_TEN)
      else $error("voltage above range");
   cover property (c_q.start_source_select && sel && channel_out.running);
   cover property ($rose(channel_out.active));
   cover property (pwm_control_write && pwm_control_group.relay_close);
endmodule
bind ssp_pwm_channel ssp_chk #(.CHANNEL_INDEX(CHANNEL_INDEX),
   .INIT_LOW_VOLT(INIT_LOW_VOLT), .INIT_RELAY(INIT_RELAY)) chk (
   .clock(clock), .sys_rst(sys_rst),
   .group_start_flag_a(group_start_flag_a),
   .group_start_flag_b(group_start_flag_b),
   .group_start_flag_c(group_start_flag_c),
   .group_start_flag_d(group_start_flag_d),
   .pwm_control_write(pwm_control_write),
   .pwm_control_group(pwm_control_group), .channel_out(channel_out));
`default_nettype wire

/* File: testbench/ssp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ssp_host_model
   import ssp_pkg::*;
(
   input  wire logic   clock,
   output logic [11:0] wr,
   output ssp_ctrl_t   ctrl,
   output logic [3:0]  flags
);
   initial begin
      wr = 12'h000;
      ctrl = '0;
      flags = 4'h0;
   end
   // one function per group
   // every channel is set up as pwm, so no group mixes functions
   task automatic send(input logic [11:0] m, input ssp_ctrl_t c);
      @(negedge clock);
      wr = m;
      ctrl = c;
      @(negedge clock);
      wr = 12'h000;
      // data only valid with the strobe; garble it afterwards
      ctrl = ~c;
   endtask
   task automatic set_flags(input logic [3:0] f);
      @(negedge clock);
      flags = f;
   endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench
   import ssp_pkg::*;
;
   localparam logic [31:0] INIT_V = 32'h40000000;
   logic        clock;
   logic        sys_rst;
   logic [11:0] wr;
   logic [3:0]  flags;
   ssp_ctrl_t   ctrl;
   ssp_out_t    outs [12];
   int          err_count;
   int          checked;
   logic [31:0] volts [4] = '{32'h00000000, REAL_ONE, 32'h40200000, REAL_TEN};
   logic [31:0] duty [4] = '{32'h00000000, 32'h3E800000, 32'h3F000000,
                             32'h3F400000};
   always #10 clock = ~clock;
   ssp_host_model host (.clock(clock), .wr(wr), .ctrl(ctrl), .flags(flags));
   for (genvar g = 0; g < 12; g++) begin : ch
      ssp_pwm_channel #(.CHANNEL_INDEX(g), .INIT_LOW_VOLT(INIT_V),
         .INIT_RELAY(1'(g % 2))) uut (.clock(clock), .sys_rst(sys_rst),
         .group_start_flag_a(flags[0]), .group_start_flag_b(flags[1]),
         .group_start_flag_c(flags[2]), .group_start_flag_d(flags[3]),
         .pwm_control_write(wr[g]), .pwm_control_group(ctrl),
         .channel_out(outs[g]));
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         err_count++;
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   function automatic ssp_ctrl_t mk(input logic s, input logic r,
      input logic [31:0] f, input logic [31:0] d, input logic [31:0] lo,
      input logic [31:0] hi, input logic rl);
      mk = {s, r, f, d, lo, hi, rl};
   endfunction
   function automatic int per_of(input logic [31:0] f);
      per_of = CLOCK_HZ / ((f == REAL_FMAX) ? MAX_FREQ_HZ : 5000);
   endfunction
   // bounded: a stuck level ends the run
   task automatic span(input logic lvl, output int n);
      n = 0;
      while (outs[0].active === lvl && n < 12000) begin
         @(negedge clock);
         n++;
      end
      if (n == 12000) begin
         err_count++;
         report_and_stop();
      end
   endtask
   task automatic init_check();
      for (int i = 0; i < 12; i++) begin
         check(outs[i].voltage, INIT_V);
         check(outs[i].relay_closed, i % 2);
      end
   endtask
   initial begin
      logic [31:0] f;
      int          p;
      int          h;
      int          l;
      int          k;
      logic        r;
      clock = 1'b0;
      sys_rst = 1'b1;
      err_count = 0;
      checked = 0;
      void'($urandom(32024));
      repeat (6) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'b0;
      init_check();
      host.send(12'h002, mk(1'b0, 1'b0, REAL_FMAX, duty[2], volts[2],
                            volts[3], 1'b1));
      check(outs[1].relay_closed, 1);
      check(outs[1].voltage, volts[2]);
      check(outs[0].voltage, INIT_V);
      check(outs[0].relay_closed, 0);
      repeat (8) begin
         k = $urandom_range(11);
         r = 1'($urandom_range(1));
         h = $urandom_range(3);
         l = $urandom_range(3);
         host.send(12'(1 << k), mk(1'b0, 1'b0, REAL_FMAX, REAL_ONE, volts[l],
                                   volts[h], r));
         check(outs[k].relay_closed, r);
         check(outs[k].voltage, volts[l]);
      end
      host.send(12'hFFF, mk(1'b1, 1'b0, REAL_FMAX, duty[2], volts[0],
                            volts[3], 1'b1));
      for (int g = 0; g < 4; g++) begin
         host.set_flags(4'(1 << g));
         repeat (45) @(negedge clock);
         for (int i = 0; i < 12; i++) begin
            check(outs[i].running, i / 3 == g);
            f = (i / 3 == g) ? volts[3] : volts[0];
            check(outs[i].voltage, f);
         end
         host.set_flags(4'h0);
         repeat (2) @(negedge clock);
         check(outs[3 * g].running, 0);
      end
      repeat (2) begin
         f = $urandom_range(1) ? REAL_FMAX : 32'h459C4000;
         p = per_of(f);
         k = $urandom_range(3, 1);
         host.send(12'h001, mk(1'b0, 1'b0, f, duty[k], volts[0], volts[3],
                               1'b0));
         host.send(12'h001, mk(1'b0, 1'b1, f, duty[k], volts[0], volts[3],
                               1'b0));
         span(1'b0, l);
         span(1'b1, h);
         span(1'b0, l);
         span(1'b1, h);
         span(1'b0, l);
         check(h, p * k / 4);
         check(h + l, p);
      end
      host.send(12'h001, mk(1'b0, 1'b0, REAL_FMAX, duty[2], volts[0],
                            volts[3], 1'b0));
      @(negedge clock);
      check(outs[0].running, 0);
      // corner cases: levels out of range, full and zero duty
      host.send(12'h001, mk(1'b0, 1'b0, REAL_FMAX, REAL_ONE, 32'h41400000,
                            32'hC0000000, 1'b0));
      check(outs[0].voltage, REAL_TEN);
      host.send(12'h001, mk(1'b0, 1'b1, REAL_FMAX, REAL_ONE, 32'h41400000,
                            32'hC0000000, 1'b0));
      repeat (45) @(negedge clock);
      check(outs[0].active, 1);
      check(outs[0].voltage, 32'h00000000);
      repeat (3000) @(negedge clock);
      check(outs[0].active, 1);
      host.send(12'h001, mk(1'b0, 1'b1, REAL_FMAX, 32'h00000000, volts[0],
                            volts[3], 1'b0));
      repeat (45) @(negedge clock);
      check({outs[0].running, outs[0].active}, 2'b10);
      // reset in mid-run brings back the initial levels and relays
      sys_rst = 1'b1;
      repeat (2) @(negedge clock);
      sys_rst = 1'b0;
      init_check();
      check(outs[0].running, 0);
      host.send(12'h001, mk(1'b0, 1'b1, 32'h00000000, duty[2], volts[0],
                            volts[3], 1'b0));
      repeat (45) @(negedge clock);
      check({outs[0].running, outs[0].active}, 2'b00);
      report_and_stop();
   end
endmodule
`default_nettype wire
